//--- rtl/sar_defines.svh
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

// Result word
`define SAR_RES_W 18
`define SAR_RES_MSB 17

// Clock period of both ends' system clock
`define SAR_CLK_NS 20

// Reinitialisation period after a supply event
`define SAR_POR_WAIT_NS 20000
`define SAR_POR_WAIT_CYC ((`SAR_POR_WAIT_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)

// Longest conversion time, rounded down
`define SAR_CONV_MAX_NS 1500
`define SAR_CONV_CYC (`SAR_CONV_MAX_NS / `SAR_CLK_NS)

// Acquisition start after conversion start, rounded up
`define SAR_ACQ_START_NS 527
`define SAR_ACQ_START_CYC ((`SAR_ACQ_START_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)

// Acquisition window that results
`define SAR_ACQ_WIN_NS 1460

// Window for extra start-line transitions, rounded down
`define SAR_START_QUIET_NS 40
`define SAR_START_HI_CYC (`SAR_START_QUIET_NS / `SAR_CLK_NS)

// Host shift clock half period in system clocks
`define SAR_SCK_HALF_CYC 4

// Width of the cycle counters
`define SAR_CNT_W 11

`endif

//--- rtl/sar_pkg.sv
package sar_pkg;

    // Device conversion sequencer states
    typedef enum logic [1:0] {
        SAR_DEV_POR,
        SAR_DEV_INIT,
        SAR_DEV_IDLE,
        SAR_DEV_CONV
    } sar_dev_state_e;

    // Host sequencer states
    typedef enum logic [2:0] {
        SAR_HOST_POR_WAIT,
        SAR_HOST_IDLE,
        SAR_HOST_START_HI,
        SAR_HOST_WAIT_HI,
        SAR_HOST_WAIT_LO,
        SAR_HOST_SHIFT
    } sar_host_state_e;

    typedef logic [17:0] sar_word_t;

endpackage

//--- rtl/sar_link_if.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Link between host and converter; sdo level is resolved by the bench
interface sar_link_if;
    logic convert_start;
    logic sck;
    logic read_select_or_serial_in;
    logic chain_select;
    logic busy;
    logic sdo;
    logic sdo_oe;
    // Shared data line level as the host sees it
    logic sdo_line;

    modport device (
        input convert_start,
        input sck,
        input read_select_or_serial_in,
        input chain_select,
        output busy,
        output sdo,
        output sdo_oe
    );

    modport host (
        output convert_start,
        output sck,
        output read_select_or_serial_in,
        output chain_select,
        input busy,
        input sdo,
        input sdo_oe,
        input sdo_line
    );
endinterface // sar_link_if

//--- rtl/sar_sync2.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Two-stage level synchroniser
module sar_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_r;

    // First stage read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sar_sync2

//--- rtl/sar_dev_end.sv
// Overview of operation
// - Reset and reinitialise on low supply
// - Host waits 20us after reset event
// - Start-line rising edge starts conversion, wakes
// - Starts ignored while converting
// - Busy high throughout conversion
// - Host keeps start line quiet during conversion
// - Power down and acquire after conversion
// - Acquisition begins 527ns after start; the code waits 27 clocks (540ns) after the start edge
// - Internally timed, done within 1.5us
// - Last result kept while powered down
// - Host idles output and clock in power-down
// - Shift only on clock edges when enabled
// - Read after conversion, fast clock
// - Data changes on rising clock edge
// - Normal mode: select high floats output
// - Result msb appears at busy fall
// - Shared output: one select low at once
// - Select low presents result msb at once
// - Chain mode: output always driven, serial in
// - Chain captures input each rising edge
// - Result is straight unsigned binary
`timescale 1ns/10ps
`include "sar_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Converter end: sequencer on clk, output shifter on the link clock
module sar_dev_end (
    input wire logic clk,
    input wire logic rst_n,
    sar_link_if.device lnk,
    input wire logic supply_ok,
    input wire logic [`SAR_RES_MSB:0] sample_code,
    output logic power_down,
    output logic acquiring,
    output logic conv_done,
    output logic init_done
);
    localparam logic [`SAR_CNT_W-1:0] POR_LAST = `SAR_CNT_W'(`SAR_POR_WAIT_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] CONV_LAST = `SAR_CNT_W'(`SAR_CONV_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] ACQ_LAST = `SAR_CNT_W'(`SAR_ACQ_START_CYC - 1);

    sar_pkg::sar_dev_state_e st_r;
    logic [`SAR_CNT_W-1:0] cyc_r;
    logic start_s;
    logic start_q_r;
    logic supply_s;
    logic start_edge;
    logic busy_r;
    logic power_down_r;
    logic acquiring_r;
    logic conv_done_r;
    logic init_done_r;
    sar_pkg::sar_word_t result_r;
    sar_pkg::sar_word_t shreg_r;
    logic loaded_r;
    logic shift_en;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers into clk
    sar_sync2 u_start_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(lnk.convert_start),
        .q(start_s)
    );

    sar_sync2 u_supply_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(supply_ok),
        .q(supply_s)
    );

    // Previous start-line level for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q_r <= 1'b0;
        end else begin
            start_q_r <= start_s;
        end
    end

    assign start_edge = start_s & ~start_q_r;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= sar_pkg::SAR_DEV_POR;
            cyc_r <= '0;
        end else if (!supply_s) begin
            st_r <= sar_pkg::SAR_DEV_POR;
            cyc_r <= '0;
        end else begin
            case (st_r)
                sar_pkg::SAR_DEV_POR: begin
                    st_r <= sar_pkg::SAR_DEV_INIT;
                    cyc_r <= '0;
                end
                sar_pkg::SAR_DEV_INIT: begin
                    // Starts during reinitialisation would be invalid
                    if (cyc_r == POR_LAST) begin
                        st_r <= sar_pkg::SAR_DEV_IDLE;
                        cyc_r <= '0;
                    end else begin
                        cyc_r <= cyc_r + 1'b1;
                    end
                end
                sar_pkg::SAR_DEV_IDLE: begin
                    if (start_edge) begin
                        st_r <= sar_pkg::SAR_DEV_CONV;
                        cyc_r <= '0;
                    end
                end
                sar_pkg::SAR_DEV_CONV: begin
                    // Edges here are ignored until the count ends
                    if (cyc_r == CONV_LAST) begin
                        st_r <= sar_pkg::SAR_DEV_IDLE;
                        cyc_r <= '0;
                    end else begin
                        cyc_r <= cyc_r + 1'b1;
                    end
                end
                default: begin
                    st_r <= sar_pkg::SAR_DEV_POR;
                    cyc_r <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Busy flag, high exactly while converting
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_s) begin
            busy_r <= 1'b0;
        end else if (st_r == sar_pkg::SAR_DEV_IDLE && start_edge) begin
            busy_r <= 1'b1;
        end else if (st_r == sar_pkg::SAR_DEV_CONV && cyc_r == CONV_LAST) begin
            busy_r <= 1'b0;
        end
    end

    // Low-power flag, set after each conversion
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_s) begin
            power_down_r <= 1'b1;
        end else if (st_r == sar_pkg::SAR_DEV_IDLE && start_edge) begin
            power_down_r <= 1'b0;
        end else if (st_r == sar_pkg::SAR_DEV_CONV && cyc_r == CONV_LAST) begin
            power_down_r <= 1'b1;
        end
    end

    // Acquisition flag: from the ACQ_LAST conversion cycle (27 cycles after start) until next start
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_s) begin
            acquiring_r <= 1'b0;
        end else if (st_r == sar_pkg::SAR_DEV_IDLE && start_edge) begin
            acquiring_r <= 1'b0;
        end else if (st_r == sar_pkg::SAR_DEV_CONV && cyc_r == ACQ_LAST) begin
            acquiring_r <= 1'b1;
        end else if (st_r == sar_pkg::SAR_DEV_IDLE) begin
            acquiring_r <= 1'b1;
        end
    end

    // Result capture at conversion end, kept through power-down
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_s) begin
            result_r <= '0;
        end else if (st_r == sar_pkg::SAR_DEV_CONV && cyc_r == CONV_LAST) begin
            result_r <= sample_code;
        end
    end

    // Conversion-done pulse and init status
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_done_r <= 1'b0;
            init_done_r <= 1'b0;
        end else begin
            conv_done_r <= (st_r == sar_pkg::SAR_DEV_CONV) && (cyc_r == CONV_LAST);
            init_done_r <= supply_s && (st_r == sar_pkg::SAR_DEV_IDLE ||
                st_r == sar_pkg::SAR_DEV_CONV);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-clock output shifter
    // Busy is a clean flop and clears the shifter while converting; the
    // result word is static whenever busy is low, except on supply loss, so it crosses safely.
    assign shift_en = lnk.chain_select | ~lnk.read_select_or_serial_in;

    always_ff @(posedge lnk.sck or posedge busy_r) begin
        if (busy_r) begin
            loaded_r <= 1'b0;
            shreg_r <= '0;
        end else if (shift_en) begin
            loaded_r <= 1'b1;
            // First edge takes result, later edges shift; input enters lsb
            if (!loaded_r) begin
                shreg_r <= {result_r[`SAR_RES_MSB-1:0], lnk.read_select_or_serial_in};
            end else begin
                shreg_r <= {shreg_r[`SAR_RES_MSB-1:0], lnk.read_select_or_serial_in};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs
    // Msb stands until the first rising edge, then the shifter leads
    assign lnk.sdo = loaded_r ? shreg_r[`SAR_RES_MSB] : result_r[`SAR_RES_MSB];
    // Chain: always driven; normal: select low drives
    assign lnk.sdo_oe = lnk.chain_select | ~lnk.read_select_or_serial_in;
    assign lnk.busy = busy_r;

    // User-side status
    assign power_down = power_down_r;
    assign acquiring = acquiring_r;
    assign conv_done = conv_done_r;
    assign init_done = init_done_r;
endmodule // sar_dev_end

//--- rtl/sar_host_end.sv
`timescale 1ns/10ps
`include "sar_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Host end: starts conversions, makes the shift clock, collects words
module sar_host_end #(
    parameter int WORDS = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    sar_link_if.host lnk,
    input wire logic start_req,
    input wire logic chain_mode,
    output logic ready,
    output logic [`SAR_RES_MSB:0] data_out,
    output logic data_valid
);
    localparam logic [`SAR_CNT_W-1:0] POR_LAST = `SAR_CNT_W'(`SAR_POR_WAIT_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] HI_LAST = `SAR_CNT_W'(`SAR_START_HI_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] PH_RISE = `SAR_CNT_W'(`SAR_SCK_HALF_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] PH_FALL = `SAR_CNT_W'(2 * `SAR_SCK_HALF_CYC - 1);
    localparam logic [4:0] BIT_LAST = 5'(`SAR_RES_W - 1);
    localparam logic [7:0] WORD_LAST = 8'(WORDS - 1);

    sar_pkg::sar_host_state_e st_r;
    logic [`SAR_CNT_W-1:0] cnt_r;
    logic [4:0] bit_r;
    logic [7:0] word_r;
    sar_pkg::sar_word_t sh_r;
    logic busy_s;
    logic sdo_s;
    logic start_r;
    logic sck_r;
    logic sel_r;
    logic chain_r;
    logic valid_r;
    sar_pkg::sar_word_t out_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    sar_sync2 u_busy_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(lnk.busy),
        .q(busy_s)
    );

    sar_sync2 u_sdo_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(lnk.sdo_line),
        .q(sdo_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and link pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= sar_pkg::SAR_HOST_POR_WAIT;
            cnt_r <= '0;
            bit_r <= '0;
            word_r <= '0;
            sh_r <= '0;
            start_r <= 1'b0;
            sck_r <= 1'b0;
            sel_r <= 1'b1;
            chain_r <= 1'b0;
        end else begin
            case (st_r)
                sar_pkg::SAR_HOST_POR_WAIT: begin
                    if (cnt_r == POR_LAST) begin
                        st_r <= sar_pkg::SAR_HOST_IDLE;
                    end
                    cnt_r <= cnt_r + 1'b1;
                end
                sar_pkg::SAR_HOST_IDLE: begin
                    chain_r <= chain_mode;
                    sel_r <= ~chain_mode;
                    if (start_req) begin
                        st_r <= sar_pkg::SAR_HOST_START_HI;
                        start_r <= 1'b1;
                        cnt_r <= '0;
                    end
                end
                sar_pkg::SAR_HOST_START_HI: begin
                    // Falling edge inside the quiet window
                    if (cnt_r == HI_LAST) begin
                        start_r <= 1'b0;
                        st_r <= sar_pkg::SAR_HOST_WAIT_HI;
                    end
                    cnt_r <= cnt_r + 1'b1;
                end
                sar_pkg::SAR_HOST_WAIT_HI: begin
                    if (busy_s) begin
                        st_r <= sar_pkg::SAR_HOST_WAIT_LO;
                    end
                end
                sar_pkg::SAR_HOST_WAIT_LO: begin
                    // Read only after the conversion ends
                    if (!busy_s) begin
                        st_r <= sar_pkg::SAR_HOST_SHIFT;
                        sel_r <= 1'b0;
                        cnt_r <= '0;
                        bit_r <= '0;
                        word_r <= '0;
                    end
                end
                sar_pkg::SAR_HOST_SHIFT: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == PH_RISE) begin
                        // Sample the stable bit, then raise the clock
                        sh_r <= {sh_r[`SAR_RES_MSB-1:0], sdo_s};
                        sck_r <= 1'b1;
                    end else if (cnt_r == PH_FALL) begin
                        sck_r <= 1'b0;
                        cnt_r <= '0;
                        bit_r <= bit_r + 1'b1;
                        if (bit_r == BIT_LAST) begin
                            bit_r <= '0;
                            word_r <= word_r + 1'b1;
                            if (word_r == WORD_LAST) begin
                                // Idle the link in power-down
                                st_r <= sar_pkg::SAR_HOST_IDLE;
                                sel_r <= ~chain_r;
                            end
                        end
                    end
                end
                default: begin
                    st_r <= sar_pkg::SAR_HOST_IDLE;
                    start_r <= 1'b0;
                    sck_r <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word output, one pulse per 18 sampled bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            out_r <= '0;
        end else begin
            valid_r <= 1'b0;
            if (st_r == sar_pkg::SAR_HOST_SHIFT && cnt_r == PH_RISE && bit_r == BIT_LAST) begin
                valid_r <= 1'b1;
                out_r <= {sh_r[`SAR_RES_MSB-1:0], sdo_s};
            end
        end
    end

    assign lnk.convert_start = start_r;
    assign lnk.sck = sck_r;
    assign lnk.read_select_or_serial_in = sel_r;
    assign lnk.chain_select = chain_r;
    assign ready = (st_r == sar_pkg::SAR_HOST_IDLE);
    assign data_out = out_r;
    assign data_valid = valid_r;
endmodule // sar_host_end

//--- sim/sar_link_properties.sv
`timescale 1ns/10ps
`include "sar_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Timing checks on the link between host and converter
module sar_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic convert_start,
    input wire logic sck,
    input wire logic read_select_or_serial_in,
    input wire logic chain_select,
    input wire logic busy,
    input wire logic sdo,
    input wire logic sdo_oe
);
    localparam int CONV_CYC = `SAR_CONV_CYC;
    logic [`SAR_CNT_W-1:0] busy_cnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles of busy high so far
    always_ff @(posedge clk) begin
        if (!rst_n || !busy) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_busy_len;
        $fell(busy) |-> busy_cnt_r == CONV_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    property p_busy_max;
        busy |-> busy_cnt_r < CONV_CYC;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("conversion too long");
    property p_start_busy;
        $rose(convert_start) |-> ##[2:6] busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("no busy after start");
    property p_start_pulse;
        $rose(convert_start) |=> convert_start ##1 !convert_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse width off");
    property p_start_quiet;
        busy |-> !convert_start;
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("start line moved");
    property p_oe_normal;
        !chain_select |-> sdo_oe == !read_select_or_serial_in;
    endproperty
    a_oe_normal: assert property (p_oe_normal) else $error("output enable wrong");
    property p_oe_chain;
        chain_select |-> sdo_oe;
    endproperty
    a_oe_chain: assert property (p_oe_chain) else $error("output not driven in chain");
    property p_sck_idle;
        !sdo_oe |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock runs while disabled");
    property p_sck_busy;
        busy |-> !sck;
    endproperty
    a_sck_busy: assert property (p_sck_busy) else $error("clock runs in conversion");
    property p_sdo_hold;
        sdo_oe && $stable(sdo_oe) && !busy && $stable(busy) && $stable(chain_select)
            && !$rose(sck) |-> $stable(sdo);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("data moved off clock edge");
endmodule // sar_link_properties

//--- sim/sar_adc_conversion_serial_readout_bench.sv
`timescale 1ns/10ps
`include "sar_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Both ends joined; corner and random words converted and read back
module sar_adc_conversion_serial_readout_bench;
    logic clk;
    logic rst_n;
    logic supply_ok;
    sar_pkg::sar_word_t sample_code;
    logic start_req;
    logic chain_mode;
    logic power_down;
    logic acquiring;
    logic conv_done;
    logic init_done;
    logic ready;
    sar_pkg::sar_word_t data_out;
    logic data_valid;
    int err_count;
    int num_checks;
    logic [31:0] seed;

    sar_link_if u_sar_link_if ();

    sar_dev_end u_sar_dev_end (
        .clk(clk),
        .rst_n(rst_n),
        .lnk(u_sar_link_if),
        .supply_ok(supply_ok),
        .sample_code(sample_code),
        .power_down(power_down),
        .acquiring(acquiring),
        .conv_done(conv_done),
        .init_done(init_done)
    );

    sar_host_end #(.WORDS(1)) u_sar_host_end (
        .clk(clk),
        .rst_n(rst_n),
        .lnk(u_sar_link_if),
        .start_req(start_req),
        .chain_mode(chain_mode),
        .ready(ready),
        .data_out(data_out),
        .data_valid(data_valid)
    );

    sar_link_properties u_sar_link_properties (
        .clk(clk),
        .rst_n(rst_n),
        .convert_start(u_sar_link_if.convert_start),
        .sck(u_sar_link_if.sck),
        .read_select_or_serial_in(u_sar_link_if.read_select_or_serial_in),
        .chain_select(u_sar_link_if.chain_select),
        .busy(u_sar_link_if.busy),
        .sdo(u_sar_link_if.sdo),
        .sdo_oe(u_sar_link_if.sdo_oe)
    );

    // Shared data line; a released output reads inverted
    assign u_sar_link_if.sdo_line = u_sar_link_if.sdo_oe ? u_sar_link_if.sdo
        : ~u_sar_link_if.sdo;

    ////////////////////////////////////////////////////////////////////////////
    // Xorshift step
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Signal picked for a bounded wait
    function automatic logic sel(input int w);
        case (w)
            0: return data_valid;
            1: return init_done;
            2: return u_sar_link_if.busy;
            3: return acquiring;
            default: return ready;
        endcase
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input sar_pkg::sar_word_t exp,
                            input sar_pkg::sar_word_t got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Wait on falling edges until the level shows, bounded
    task automatic wait_for(input int w, input logic lvl, input int lim, output int n);
        n = 0;
        while (sel(w) !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (sel(w) !== lvl) begin
            err_count++;
            $display("wrong value wait %0d expected %0b seen %0b", w, lvl, sel(w));
            close_out();
        end
    endtask

    // One conversion and read, timing measured on the way
    task automatic do_conv(input sar_pkg::sar_word_t code, input logic chain);
        int n;
        int hi;
        wait_for(4, 1'b1, 200, n);
        sample_code = code;
        chain_mode = chain;
        start_req = 1'b1;
        wait_for(2, 1'b1, 20, n);
        start_req = 1'b0;
        wait_for(3, 1'b1, 100, hi);
        chk_num("acquire start", `SAR_ACQ_START_CYC, hi);
        wait_for(2, 1'b0, 100, n);
        chk_num("busy cycles", `SAR_CONV_CYC, hi + n);
        chk_bit("power down", 1'b1, power_down);
        chk_bit("msb at busy fall", code[17], u_sar_link_if.sdo);
        chk_bit("output enable", chain, u_sar_link_if.sdo_oe);
        chk_bit("done pulse", 1'b1, conv_done);
        @(negedge clk);
        chk_bit("done pulse end", 1'b0, conv_done);
        wait_for(0, 1'b1, 600, n);
        chk_word("read word", code, data_out);
        chk_bit("power down in read", 1'b1, power_down);
        if (chain) begin
            chk_bit("upstream msb", 1'b0, u_sar_link_if.sdo);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // System clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Main sequence
    initial begin
        int n;
        sar_pkg::sar_word_t corner [4];
        corner = '{18'h00000, 18'h3ffff, 18'h20000, 18'h15555};
        rst_n = 1'b0;
        supply_ok = 1'b1;
        sample_code = 18'h00000;
        start_req = 1'b0;
        chain_mode = 1'b0;
        err_count = 0;
        num_checks = 0;
        seed = 32'h1eb814c2;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk_bit("power down at reset", 1'b1, power_down);
        wait_for(1, 1'b1, 1200, n);
        wait_for(4, 1'b1, 1200, n);
        // Corner codes (zero, full scale, msb only, alternating bits), both modes
        for (int i = 0; i < 4; i++) begin
            do_conv(corner[i], !i[0]);
        end
        // Supply drop while idle, then reinit
        supply_ok = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit("busy in drop", 1'b0, u_sar_link_if.busy);
        chk_bit("init in drop", 1'b0, init_done);
        supply_ok = 1'b1;
        wait_for(1, 1'b1, 1200, n);
        // Random codes and modes
        for (int i = 0; i < 12; i++) begin
            seed = next_rand(seed);
            do_conv(seed[17:0], seed[31]);
        end
        close_out();
    end
endmodule // sar_adc_conversion_serial_readout_bench
